// ===== verilog/tpo_pkg.sv
`default_nettype none
package tpo_pkg;
  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 18;
  localparam int          DATA_W      = 32;
  localparam int          REG_W       = 8;
  localparam int          GROUP_N     = 4;
  localparam int          SEL_W       = 2;

  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_DIR_LO  = 16'hffd1;
  localparam logic [15:0] IDX_OUT_LO  = 16'hffd3;
  localparam logic [15:0] IDX_DIR_HI  = 16'hffd4;
  localparam logic [15:0] IDX_OUT_HI  = 16'hffd6;
  localparam logic [15:0] IDX_TRIG    = 16'hffa1;
  localparam logic [15:0] IDX_EN_HI   = 16'hffa2;
  localparam logic [15:0] IDX_EN_LO   = 16'hffa3;
  localparam logic [15:0] IDX_ND_HI_A = 16'hffa4;
  localparam logic [15:0] IDX_ND_LO_A = 16'hffa5;
  localparam logic [15:0] IDX_ND_HI_B = 16'hffa6;
  localparam logic [15:0] IDX_ND_LO_B = 16'hffa7;

  // ----------------------------------------------------------------
  // Reset values and field masks
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_DIR     = 8'h00;
  localparam logic [7:0]  RST_OUT     = 8'h00;
  localparam logic [7:0]  RST_ND      = 8'h00;
  localparam logic [7:0]  RST_EN      = 8'h00;
  localparam logic [7:0]  RST_TRIG    = 8'hff;
  localparam logic [7:0]  ALL_ONES    = 8'hff;
  localparam logic [7:0]  NIB_HI      = 8'hf0;
  localparam logic [7:0]  NIB_LO      = 8'h0f;
  localparam int          NO_PIN_BIT  = 6;
endpackage : tpo_pkg
`default_nettype wire

// ===== verilog/tpo_regs.sv
// Added by the designer: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module tpo_regs #(
  parameter int CHAN_N = 4,
  parameter int PORT_W = 8
) (
  input  wire logic                        core_clk,
  input  wire logic                        sys_rst,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [tpo_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [tpo_pkg::DATA_W-1:0]  pwdata,
  output logic      [tpo_pkg::DATA_W-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [CHAN_N-1:0]           cmp_match,
  output logic      [PORT_W-1:0]           low_pin_out,
  output logic      [PORT_W-1:0]           low_pin_oe,
  output logic      [PORT_W-1:0]           high_pin_out,
  output logic      [PORT_W-1:0]           high_pin_oe
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The trigger decode indexes one compare line per channel code,
  // so the channel count must match the two-bit select exactly
  // Port width is tied to the byte-wide register image
  if (CHAN_N != tpo_pkg::GROUP_N) begin : g_chan_chk
    $error("tpo_regs: CHAN_N must equal the group count");
  end
  if (PORT_W != tpo_pkg::REG_W) begin : g_port_chk
    $error("tpo_regs: PORT_W must be eight");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // All state in one word, registered in one place
  // Direction registers are write-only and never read back
  // Read data and error flag are latched in setup, stand for access
  typedef struct packed {
    logic [7:0]  low_port_direction;
    logic [7:0]  high_port_direction;
    logic [7:0]  low_port_output_data;
    logic [7:0]  high_port_output_data;
    logic [7:0]  next_data_low;
    logic [7:0]  next_data_high;
    logic [7:0]  next_data_enable_low;
    logic [7:0]  next_data_enable_high;
    logic [7:0]  trigger_select_reg;
    logic [31:0] rdata;
    logic        slverr;
  } tpo_state_s;

  tpo_state_s state_reg;
  tpo_state_s state_next;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte address match against a register index
  // Registers sit on word boundaries; the two low address
  // bits must be zero for a hit, so byte accesses miss
  function automatic logic tpo_hit(input logic [tpo_pkg::ADDR_W-1:0] a,
                                   input logic [15:0]                idx);
    tpo_hit = (a == {idx, 2'b00});
  endfunction : tpo_hit

  // Replace the bits selected by mask
  // Used for read-only port bits, reserved nibbles and the copy
  function automatic logic [7:0] tpo_merge(input logic [7:0] old_v,
                                           input logic [7:0] new_v,
                                           input logic [7:0] mask);
    tpo_merge = (old_v & ~mask) | (new_v & mask);
  endfunction : tpo_merge

  // Widen a byte onto the bus
  function automatic logic [31:0] tpo_word(input logic [7:0] b);
    tpo_word = {24'h000000, b};
  endfunction : tpo_word

  // Copy mask: enabled bits of groups whose trigger fired
  // Upper nibble is the odd group, lower nibble the even group
  function automatic logic [7:0] tpo_copy_mask(input logic       trig_hi_nib,
                                               input logic       trig_lo_nib,
                                               input logic [7:0] en);
    tpo_copy_mask = en & ({{4{trig_hi_nib}}, {4{trig_lo_nib}}});
  endfunction : tpo_copy_mask

  // ----------------------------------------------------------------
  // Trigger decode
  // ----------------------------------------------------------------
  logic [tpo_pkg::SEL_W-1:0] grp_sel [tpo_pkg::GROUP_N];
  logic [tpo_pkg::GROUP_N-1:0] grp_fire;
  logic                      low_same;
  logic                      high_same;
  logic [7:0]                copy_low;
  logic [7:0]                copy_high;

  // Each group looks up its own channel; two groups on the
  // same channel fire together from one compare pulse
  // The same-trigger flags decide the next-data address map
  // and follow the select value live, so a change of select
  // remaps the next-data words at once
  // Per-group channel choice and its compare match
  always_comb begin
    for (int g = 0; g < tpo_pkg::GROUP_N; g++) begin
      grp_sel[g]  = state_reg.trigger_select_reg[g*tpo_pkg::SEL_W +: tpo_pkg::SEL_W];
      grp_fire[g] = cmp_match[grp_sel[g]];
    end
  end

  assign low_same  = (grp_sel[0] == grp_sel[1]);
  assign high_same = (grp_sel[2] == grp_sel[3]);
  assign copy_low  = tpo_copy_mask(grp_fire[1], grp_fire[0],
                                   state_reg.next_data_enable_low);
  assign copy_high = tpo_copy_mask(grp_fire[3], grp_fire[2],
                                   state_reg.next_data_enable_high);

  // ----------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------
  logic       setup_ph;
  logic       wr_acc;
  logic [7:0] wb;
  logic       hit_any;

  // Setup cycle: psel high, penable low; read data is latched here
  // Write access: the edge at which a write lands
  // The slave never stretches a transfer, so the access cycle
  // always ends at its first edge
  // Only the low byte of the write data reaches a register
  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite;
  assign wb       = pwdata[7:0];

  // ----------------------------------------------------------------
  // Per-register address decode
  // ----------------------------------------------------------------
  // One strobe per mapped word; an address that lights none
  // of them is answered with an error and changes nothing
  logic hit_dir_lo;
  logic hit_out_lo;
  logic hit_dir_hi;
  logic hit_out_hi;
  logic hit_trig;
  logic hit_en_hi;
  logic hit_en_lo;
  logic hit_nd_hi_a;
  logic hit_nd_lo_a;
  logic hit_nd_hi_b;
  logic hit_nd_lo_b;

  // Low port direction, write-only
  assign hit_dir_lo  = tpo_hit(paddr, tpo_pkg::IDX_DIR_LO);
  // Low port data
  assign hit_out_lo  = tpo_hit(paddr, tpo_pkg::IDX_OUT_LO);
  // High port direction, write-only
  assign hit_dir_hi  = tpo_hit(paddr, tpo_pkg::IDX_DIR_HI);
  // High port data
  assign hit_out_hi  = tpo_hit(paddr, tpo_pkg::IDX_OUT_HI);
  // Trigger select
  assign hit_trig    = tpo_hit(paddr, tpo_pkg::IDX_TRIG);
  // High enable
  assign hit_en_hi   = tpo_hit(paddr, tpo_pkg::IDX_EN_HI);
  // Low enable
  assign hit_en_lo   = tpo_hit(paddr, tpo_pkg::IDX_EN_LO);
  // High next-data, first word
  assign hit_nd_hi_a = tpo_hit(paddr, tpo_pkg::IDX_ND_HI_A);
  // Low next-data, first word
  assign hit_nd_lo_a = tpo_hit(paddr, tpo_pkg::IDX_ND_LO_A);
  // High next-data, second word
  assign hit_nd_hi_b = tpo_hit(paddr, tpo_pkg::IDX_ND_HI_B);
  // Low next-data, second word
  assign hit_nd_lo_b = tpo_hit(paddr, tpo_pkg::IDX_ND_LO_B);

  // Any mapped register
  assign hit_any = hit_dir_lo
                 | hit_out_lo
                 | hit_dir_hi
                 | hit_out_hi
                 | hit_trig
                 | hit_en_hi
                 | hit_en_lo
                 | hit_nd_hi_a
                 | hit_nd_lo_a
                 | hit_nd_hi_b
                 | hit_nd_lo_b;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] rd;
    rd         = 8'h00;
    state_next = state_reg;

    // Read data captured in the setup phase
    // Sampled at the setup edge so that it stands through the
    // access cycle whatever the pins do meanwhile
    // Reserved nibbles of the next-data words read as ones
    if (tpo_hit(paddr, tpo_pkg::IDX_OUT_LO)) begin
      rd = state_reg.low_port_output_data;
    end else if (tpo_hit(paddr, tpo_pkg::IDX_OUT_HI)) begin
      rd = state_reg.high_port_output_data;
    end else if (tpo_hit(paddr, tpo_pkg::IDX_TRIG)) begin
      rd = state_reg.trigger_select_reg;
    end else if (tpo_hit(paddr, tpo_pkg::IDX_EN_LO)) begin
      rd = state_reg.next_data_enable_low;
    end else if (tpo_hit(paddr, tpo_pkg::IDX_EN_HI)) begin
      rd = state_reg.next_data_enable_high;
    end else if (tpo_hit(paddr, tpo_pkg::IDX_ND_LO_A)) begin
      rd = low_same ? state_reg.next_data_low
                    : (state_reg.next_data_low | tpo_pkg::NIB_LO);
    end else if (tpo_hit(paddr, tpo_pkg::IDX_ND_LO_B)) begin
      rd = low_same ? tpo_pkg::ALL_ONES
                    : (state_reg.next_data_low | tpo_pkg::NIB_HI);
    end else if (tpo_hit(paddr, tpo_pkg::IDX_ND_HI_A)) begin
      rd = high_same ? state_reg.next_data_high
                     : (state_reg.next_data_high | tpo_pkg::NIB_LO);
    end else if (tpo_hit(paddr, tpo_pkg::IDX_ND_HI_B)) begin
      rd = high_same ? tpo_pkg::ALL_ONES
                     : (state_reg.next_data_high | tpo_pkg::NIB_HI);
    end
    if (setup_ph) begin
      state_next.rdata  = tpo_word(rd);        // Direction registers read as zero
      state_next.slverr = ~hit_any;
    end

    // Register writes in the access phase
    // A write lands at the edge that ends the access cycle;
    // enabled port data bits belong to the pattern logic and
    // keep their value against software writes
    // Reserved next-data nibbles swallow the written bits
    if (wr_acc) begin
      if (tpo_hit(paddr, tpo_pkg::IDX_DIR_LO)) begin
        state_next.low_port_direction = wb;
      end
      if (tpo_hit(paddr, tpo_pkg::IDX_DIR_HI)) begin
        state_next.high_port_direction = wb;
      end
      if (tpo_hit(paddr, tpo_pkg::IDX_OUT_LO)) begin
        state_next.low_port_output_data = tpo_merge(state_reg.low_port_output_data, wb,
                                          ~state_reg.next_data_enable_low);
      end
      if (tpo_hit(paddr, tpo_pkg::IDX_OUT_HI)) begin
        state_next.high_port_output_data = tpo_merge(state_reg.high_port_output_data, wb,
                                           ~state_reg.next_data_enable_high);
      end
      if (tpo_hit(paddr, tpo_pkg::IDX_TRIG)) begin
        state_next.trigger_select_reg = wb;
      end
      if (tpo_hit(paddr, tpo_pkg::IDX_EN_LO)) begin
        state_next.next_data_enable_low = wb;
      end
      if (tpo_hit(paddr, tpo_pkg::IDX_EN_HI)) begin
        state_next.next_data_enable_high = wb;
      end
      if (tpo_hit(paddr, tpo_pkg::IDX_ND_LO_A)) begin
        state_next.next_data_low = tpo_merge(state_reg.next_data_low, wb,
                                   low_same ? tpo_pkg::ALL_ONES : tpo_pkg::NIB_HI);
      end
      if (tpo_hit(paddr, tpo_pkg::IDX_ND_LO_B) && !low_same) begin
        state_next.next_data_low = tpo_merge(state_reg.next_data_low, wb,
                                             tpo_pkg::NIB_LO);
      end
      if (tpo_hit(paddr, tpo_pkg::IDX_ND_HI_A)) begin
        state_next.next_data_high = tpo_merge(state_reg.next_data_high, wb,
                                    high_same ? tpo_pkg::ALL_ONES : tpo_pkg::NIB_HI);
      end
      if (tpo_hit(paddr, tpo_pkg::IDX_ND_HI_B) && !high_same) begin
        state_next.next_data_high = tpo_merge(state_reg.next_data_high, wb,
                                              tpo_pkg::NIB_LO);
      end
    end

    // Compare-match copy; written last so it wins
    // The copy uses next-data as it stood before this edge,
    // so a same-edge write to next-data shows at the next match
    // Only enabled bits of fired groups are replaced
    state_next.low_port_output_data = tpo_merge(state_next.low_port_output_data,
                                                state_reg.next_data_low, copy_low);
    state_next.high_port_output_data = tpo_merge(state_next.high_port_output_data,
                                                 state_reg.next_data_high, copy_high);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Asynchronous clear; only constants in the reset branch
  // Trigger select clears to all ones, channel 3 for every group
  // Pins come out of reset undriven with all port data low
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg.low_port_direction    <= tpo_pkg::RST_DIR;
      state_reg.high_port_direction   <= tpo_pkg::RST_DIR;
      state_reg.low_port_output_data  <= tpo_pkg::RST_OUT;
      state_reg.high_port_output_data <= tpo_pkg::RST_OUT;
      state_reg.next_data_low         <= tpo_pkg::RST_ND;
      state_reg.next_data_high        <= tpo_pkg::RST_ND;
      state_reg.next_data_enable_low  <= tpo_pkg::RST_EN;
      state_reg.next_data_enable_high <= tpo_pkg::RST_EN;
      state_reg.trigger_select_reg    <= tpo_pkg::RST_TRIG;
      state_reg.rdata                 <= 32'h00000000;
      state_reg.slverr                <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Zero-wait bus answer
  // Every access completes in one access cycle; the error
  // flag marks addresses outside the map
  assign pready  = 1'b1;
  assign prdata  = state_reg.rdata;
  assign pslverr = state_reg.slverr;

  // Pins follow port data; direction sets drive (software duty)
  // A pattern pin with its direction bit clear stays undriven
  // although its port data bit still takes the copy
  assign low_pin_out = state_reg.low_port_output_data;
  assign low_pin_oe  = state_reg.low_port_direction;

  // Bit 14 has no pad and never leaves the chip
  // The register bit itself stays readable and writable;
  // only the pin and its enable are held low
  always_comb begin
    high_pin_out = state_reg.high_port_output_data;
    high_pin_oe  = state_reg.high_port_direction;
    high_pin_out[tpo_pkg::NO_PIN_BIT] = 1'b0;
    high_pin_oe[tpo_pkg::NO_PIN_BIT]  = 1'b0;
  end

  // ----------------------------------------------------------------
  // Usage notes
  // ----------------------------------------------------------------
  // Software sets the direction bit of every pin that carries
  // a pattern; a cleared bit keeps the pad undriven while the
  // port data bit still follows the copy
  // Set the enables only after next-data and the trigger select
  // hold their final values, or the first match copies stale data
  // Changing a trigger select remaps the next-data words at once;
  // rewrite next-data after such a change
  // Trigger mode and non-overlap control are not part of this block
  // A compare pulse is expected to last one clock; a longer pulse
  // repeats the copy, which is harmless but copies newer data

endmodule : tpo_regs
`default_nettype wire

// ===== bench/tpo_timer_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Timer side: one-cycle compare-match pulses on request
// ----------------------------------------------------------------
module tpo_timer_model (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] fire,
  output logic      [3:0] cmp_match
);
  // Pulse lasts exactly one cycle per request cycle
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmp_match <= 4'h0;
    end else begin
      cmp_match <= fire;
    end
  end
endmodule : tpo_timer_model
`default_nettype wire

// ===== bench/tpo_regs_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Port-level checker
// ----------------------------------------------------------------
module tpo_regs_chk #(
  parameter int CHAN_N = 4,
  parameter int PORT_W = 8
) (
  input wire logic                       core_clk,
  input wire logic                       sys_rst,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [tpo_pkg::ADDR_W-1:0] paddr,
  input wire logic [tpo_pkg::DATA_W-1:0] pwdata,
  input wire logic [tpo_pkg::DATA_W-1:0] prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic [CHAN_N-1:0]          cmp_match,
  input wire logic [PORT_W-1:0]          low_pin_out,
  input wire logic [PORT_W-1:0]          low_pin_oe,
  input wire logic [PORT_W-1:0]          high_pin_out,
  input wire logic [PORT_W-1:0]          high_pin_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Write access phase to one address
  sequence wr_s(logic [17:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence
  // No write and no compare match
  sequence quiet_s;
    !(psel && penable && pwrite) && cmp_match == '0;
  endsequence
  pready_high_a: assert property (pready) else $error("pready low");
  rd_upper_a: assert property (psel && penable |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  pin_absent_a: assert property (!high_pin_out[6] && !high_pin_oe[6])
    else $error("absent pin driven");
  lo_dir_a: assert property (wr_s({tpo_pkg::IDX_DIR_LO, 2'b00}) |=>
    low_pin_oe == $past(pwdata[7:0])) else $error("low direction not applied");
  hi_dir_a: assert property (wr_s({tpo_pkg::IDX_DIR_HI, 2'b00}) |=>
    high_pin_oe == ($past(pwdata[7:0]) & 8'hbf)) else $error("high direction wrong");
  lo_hold_a: assert property (quiet_s |=> $stable(low_pin_out))
    else $error("low output moved without cause");
  hi_hold_a: assert property (quiet_s |=> $stable(high_pin_out))
    else $error("high output moved without cause");
  oe_hold_a: assert property (!(psel && penable && pwrite) |=>
    $stable(low_pin_oe) && $stable(high_pin_oe)) else $error("direction moved");
endmodule : tpo_regs_chk
bind tpo_regs tpo_regs_chk #(.CHAN_N(CHAN_N), .PORT_W(PORT_W)) u_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cmp_match(cmp_match),
  .low_pin_out(low_pin_out), .low_pin_oe(low_pin_oe),
  .high_pin_out(high_pin_out), .high_pin_oe(high_pin_oe));
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Self-checking bench
// ----------------------------------------------------------------
module tb_top;
  logic        core_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd_d;
  logic        pready, pslverr, rd_e, sl, sh;
  logic [3:0]  cmp_match, fire = 4'h0, f;
  logic [7:0]  low_pin_out, low_pin_oe, high_pin_out, high_pin_oe;
  logic [7:0]  tr, enl, enh, ndl, ndh, ol, oh, dl, dh, w;
  int          mismatches = 0, num_checks = 0, cyc = 0;
  logic [15:0] ri [8] = '{tpo_pkg::IDX_EN_HI, tpo_pkg::IDX_EN_LO, tpo_pkg::IDX_ND_HI_A,
    tpo_pkg::IDX_ND_LO_A, tpo_pkg::IDX_TRIG, tpo_pkg::IDX_ND_HI_B, tpo_pkg::IDX_ND_LO_B,
    tpo_pkg::IDX_OUT_LO};
  logic [7:0]  re [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'h00};
  tpo_regs u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_match(cmp_match), .low_pin_out(low_pin_out),
    .low_pin_oe(low_pin_oe), .high_pin_out(high_pin_out), .high_pin_oe(high_pin_oe));
  tpo_timer_model u_tmr (.core_clk(core_clk), .sys_rst(sys_rst), .fire(fire),
    .cmp_match(cmp_match));
  // Clock and run limit
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      mismatches++;
      stop_test();
    end
  end
  // One APB transfer, request held until pready
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    @(posedge core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr;
    paddr <= {idx, 2'b00}; pwdata <= {24'h0, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd_d = prdata; rd_e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic rd(input logic [15:0] idx, input logic [7:0] e, input string m);
    apb(1'b0, idx, 8'h00);
    chk(rd_d[7:0], e, m);
  endtask : rd
  // Expected port after a compare match on groups g and g+1
  function automatic logic [7:0] cp(input logic [7:0] o, nd, en, input logic [3:0] fm,
                                    input logic [7:0] t, input int g);
    logic [7:0] m;
    m = 8'h00;
    if (fm[t[2*g +: 2]]) m |= 8'h0f;
    if (fm[t[2*g+2 +: 2]]) m |= 8'hf0;
    m &= en;
    return (o & ~m) | (nd & m);
  endfunction : cp
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  // Main sequence
  initial begin
    void'($urandom(90));
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) rd(ri[i], re[i], "reset value");
    rd(tpo_pkg::IDX_DIR_LO, 8'h00, "direction reads zero");
    apb(1'b1, 16'hffb0, 8'h55);
    chk({7'h0, rd_e}, 8'h01, "unmapped error");
    $display("test reset done");
    ol = 8'h00; oh = 8'h00;
    for (int i = 0; i < 24; i++) begin
      tr = (i == 0) ? 8'hff : (i == 1) ? 8'he4 : 8'($urandom);
      enl = (i < 2) ? 8'hff : 8'($urandom);
      enh = (i < 2) ? 8'h0f : 8'($urandom);
      f = (i == 0) ? 4'h8 : (i == 1) ? 4'h1 : 4'($urandom);
      ndl = 8'($urandom); ndh = 8'($urandom); w = 8'($urandom);
      dl = enl | 8'($urandom); dh = enh | 8'($urandom);
      sl = tr[1:0] == tr[3:2]; sh = tr[5:4] == tr[7:6];
      apb(1'b1, tpo_pkg::IDX_TRIG, tr);
      apb(1'b1, tpo_pkg::IDX_EN_LO, enl);
      apb(1'b1, tpo_pkg::IDX_EN_HI, enh);
      apb(1'b1, tpo_pkg::IDX_DIR_LO, dl);
      apb(1'b1, tpo_pkg::IDX_DIR_HI, dh);
      apb(1'b1, tpo_pkg::IDX_ND_LO_A, ndl);
      apb(1'b1, tpo_pkg::IDX_ND_LO_B, ~ndl);
      apb(1'b1, tpo_pkg::IDX_ND_HI_A, ndh);
      apb(1'b1, tpo_pkg::IDX_ND_HI_B, ~ndh);
      if (!sl) ndl = {ndl[7:4], ~ndl[3:0]};
      if (!sh) ndh = {ndh[7:4], ~ndh[3:0]};
      rd(tpo_pkg::IDX_ND_LO_A, sl ? ndl : ndl | 8'h0f, "low next A");
      rd(tpo_pkg::IDX_ND_LO_B, sl ? 8'hff : ndl | 8'hf0, "low next B");
      rd(tpo_pkg::IDX_ND_HI_A, sh ? ndh : ndh | 8'h0f, "high next A");
      rd(tpo_pkg::IDX_ND_HI_B, sh ? 8'hff : ndh | 8'hf0, "high next B");
      apb(1'b1, tpo_pkg::IDX_OUT_LO, w);
      ol = (ol & enl) | (w & ~enl);
      apb(1'b1, tpo_pkg::IDX_OUT_HI, ~w);
      oh = (oh & enh) | (~w & ~enh);
      rd(tpo_pkg::IDX_OUT_LO, ol, "low port data");
      apb(1'b0, tpo_pkg::IDX_OUT_HI, 8'h00);
      chk(rd_d[7:0] & 8'hbf, oh & 8'hbf, "high port data");
      @(posedge core_clk);
      fire <= f;
      @(posedge core_clk);
      fire <= 4'h0;
      repeat (2) @(posedge core_clk);
      #1;
      ol = cp(ol, ndl, enl, f, tr, 0);
      oh = cp(oh, ndh, enh, f, tr, 2);
      chk(low_pin_out, ol, "low pins");
      chk(high_pin_out, oh & 8'hbf, "high pins");
      chk(low_pin_oe, dl, "low direction");
      chk(high_pin_oe, dh & 8'hbf, "high direction");
    end
    $display("test transfer done");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
